// ===== stx_map.vh
// register map, field positions and timing constants of the transmit-only serial shifter
// Notes on behaviour
// - transmit only; two modes: stopped, or two-wire send on clock and data pins
// - enable low: no shifting, bit counter held clear, pins left to port use
// - stopped mode: shift register acts as plain read/write storage
// - clock field 00 external pin; 01, 10, 11 main clock divided by 4, 8, 16
// - data goes out eight bits at a time, each bit with the serial clock
// - most significant bit always goes first
// - shift on each serial clock falling edge; output latch drives the data pin
// - transfer begins at a falling clock edge that presents the first bit
// - after eight bits the block halts itself and sets the done flag
// - data write starts a transfer only if enabled and clock idle or high
// - raising enable after data already written does not start a transfer
// - reset clears the mode register: stopped, external clock selected
// - enabled: shifting allowed, counter counts serial clocks, spare pins stay ports
// - bit counter counts serial clock falling edges, internal or external, to find eight bits
`ifndef STX_MAP_VH
`define STX_MAP_VH
`define STX_ADDR_MODE     16'hFF66
`define STX_ADDR_SHIFT    16'hFF67
`define STX_MODE_RESET    8'h00
`define STX_BIT_ENABLE    7
`define STX_BIT_CLKSEL_HI 1
`define STX_BIT_CLKSEL_LO 0
`define STX_MODE_WMASK    8'h83
`define STX_CLK_EXT       2'h0
`define STX_HALF_DIV4     5'h02
`define STX_HALF_DIV8     5'h04
`define STX_HALF_DIV16    5'h08
`define STX_BITS          4'h8
`endif

// ===== stx_rx_model.sv
// far-side receiver with an optional external clock source
`timescale 1ns/100ps
`default_nettype none
module stx_rx_model (
  input  wire logic       ext_go, serial_clock_pin_out, serial_clock_pin_oe, serial_data_out_pin, serial_data_out_oe,
  output wire logic       serial_clock_pin_in,
  output var  logic [7:0] got
);
  logic ext = 1'b1; // stands high outside frames
  assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : ext;
  // low phase must outlast the three-stage pin sync plus the output register
  always @(posedge ext_go) repeat (8) begin #80 ext = 1'b0; #80 ext = 1'b1; end
  always @(posedge serial_clock_pin_in) if (serial_data_out_oe) got <= {got[6:0], serial_data_out_pin};
endmodule
`default_nettype wire

// ===== stx_shifter.v
// transmit-only clocked serial shifter with mode register and done flag
`timescale 1ns/100ps
`default_nettype none
`include "stx_map.vh"
module stx_shifter (
  // clock and reset
  input  wire        clock,
  input  wire        reset,
  // cpu register port
  input  wire [15:0] reg_addr,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // done flag
  output reg         tx_done_irq_flag,
  input  wire        tx_done_irq_clear,
  // pin direction and port latches
  input  wire        clock_pin_direction,
  input  wire        data_pin_direction,
  input  wire        clock_port_pin,
  input  wire        data_port_pin,
  // serial clock pin
  input  wire        serial_clock_pin_in,
  output reg         serial_clock_pin_out,
  output reg         serial_clock_pin_oe,
  // serial data out pin
  output reg         serial_data_out_pin,
  output reg         serial_data_out_oe,
  // status
  output reg         tx_busy
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [7:0] serial_tx_mode_control;
  reg  [7:0] tx_shift_register;
  reg  [3:0] bit_count;
  reg  [4:0] div_count;
  reg        int_clk;
  reg        data_latch;
  reg  [2:0] ext_sync;
  reg        ext_level;
  wire       serial_tx_enable = serial_tx_mode_control[`STX_BIT_ENABLE];
  wire [1:0] clk_sel = {serial_tx_mode_control[`STX_BIT_CLKSEL_HI],
                        serial_tx_mode_control[`STX_BIT_CLKSEL_LO]};
  wire       external = (clk_sel == `STX_CLK_EXT);
  reg  [4:0] half_period;

  always @* begin
    case (clk_sel)
      2'h1:    half_period = `STX_HALF_DIV4;
      2'h2:    half_period = `STX_HALF_DIV8;
      default: half_period = `STX_HALF_DIV16;
    endcase
  end

  wire wr_mode  = reg_write && (reg_addr == `STX_ADDR_MODE);
  wire wr_shift = reg_write && (reg_addr == `STX_ADDR_SHIFT);
  // clock line idle: internal clock stopped or line high after the last word
  wire line_high = external ? ext_level : int_clk;
  wire start = wr_shift && serial_tx_enable && !tx_busy && line_high;
  wire div_tick = (div_count == half_period - 5'h01);
  // falling edges: internal from divider, external once sync stages agree
  wire int_fall = tx_busy && !external && div_tick && int_clk;
  wire ext_fall = tx_busy && external && ext_level && !ext_sync[2] && !ext_sync[1];
  wire fall = int_fall || ext_fall;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser; a change counts once stages two and three agree
  always @(posedge clock) begin
    if (reset) begin
      ext_sync  <= 3'h7;
      ext_level <= 1'b1;
    end else begin
      ext_sync <= {ext_sync[1], ext_sync[0], serial_clock_pin_in};
      if (ext_sync[2] == ext_sync[1])
        ext_level <= ext_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (reset) begin
      serial_tx_mode_control <= `STX_MODE_RESET;
    end else if (wr_mode) begin
      serial_tx_mode_control <= reg_wdata & `STX_MODE_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine; a ninth falling edge would begin nothing, so the last
  // bit is held on the data latch until the first falling edge of the next transfer
  always @(posedge clock) begin
    if (reset) begin
      tx_shift_register <= 8'h00;
      bit_count         <= 4'h0;
      div_count         <= 5'h00;
      int_clk           <= 1'b1;
      data_latch        <= 1'b0;
      tx_busy           <= 1'b0;
      tx_done_irq_flag  <= 1'b0;
    end else begin
      if (!serial_tx_enable) begin
        bit_count <= 4'h0;
        tx_busy   <= 1'b0;
        int_clk   <= 1'b1;
        div_count <= 5'h00;
        if (wr_shift)
          tx_shift_register <= reg_wdata;
      end else if (start) begin
        tx_shift_register <= reg_wdata;
        bit_count         <= 4'h0;
        div_count         <= 5'h00;
        tx_busy           <= 1'b1;
      end else if (tx_busy) begin
        if (!external) begin
          div_count <= div_tick ? 5'h00 : div_count + 5'h01;
          if (div_tick)
            int_clk <= !int_clk;
        end
        if (fall) begin
          data_latch        <= tx_shift_register[7];
          tx_shift_register <= {tx_shift_register[6:0], 1'b0};
          bit_count         <= bit_count + 4'h1;
        end
        // stop on the rising edge that ends the eighth bit
        if (bit_count == `STX_BITS && line_high && !fall) begin
          tx_busy <= 1'b0;
        end
      end
      if (tx_busy && serial_tx_enable && bit_count == `STX_BITS && line_high && !fall)
        tx_done_irq_flag <= 1'b1;
      else if (tx_done_irq_clear)
        tx_done_irq_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: serial function only while enabled, port latches otherwise
  always @(posedge clock) begin
    if (reset) begin
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe  <= 1'b0;
      serial_data_out_pin  <= 1'b0;
      serial_data_out_oe   <= 1'b0;
      reg_rdata            <= 8'h00;
    end else begin
      serial_clock_pin_oe <= !clock_pin_direction;
      serial_data_out_oe  <= !data_pin_direction;
      // master clock idles high; port latch is expected to be 0
      serial_clock_pin_out <= (serial_tx_enable && !external) ? (int_clk | clock_port_pin)
                                                              : clock_port_pin;
      serial_data_out_pin  <= serial_tx_enable ? (data_latch | data_port_pin) : data_port_pin;
      if (reg_read && reg_addr == `STX_ADDR_MODE)
        reg_rdata <= serial_tx_mode_control;
      else if (reg_read && reg_addr == `STX_ADDR_SHIFT)
        reg_rdata <= tx_shift_register;
      else
        reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ===== stx_shifter_sva.sv
// port assertions for the transmit-only serial shifter
`timescale 1ns/100ps
`default_nettype none
module stx_chk (
  input wire logic        clock, reset, reg_read, tx_done_irq_flag, tx_done_irq_clear, tx_busy,
  input wire logic        serial_clock_pin_out, serial_clock_pin_oe, serial_data_out_pin,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // falls of the driven clock since the transfer began
  logic [3:0] nf;
  always @(posedge clock) nf <= (reset || $rose(tx_busy)) ? 4'h0 : nf + {3'h0, $fell(serial_clock_pin_out)};
  done_on_end_a: assert property ($fell(tx_busy) |-> tx_done_irq_flag) else $error("no flag");
  flag_cause_a: assert property ($rose(tx_done_irq_flag) |-> $fell(tx_busy)) else $error("stray flag");
  flag_hold_a: assert property (tx_done_irq_flag && !tx_done_irq_clear |=> tx_done_irq_flag) else $error("lost");
  // after a master transfer the clock rests high while the done flag stands
  idle_high_a: assert property (serial_clock_pin_oe && !tx_busy && tx_done_irq_flag && $past(tx_done_irq_flag)
    |-> serial_clock_pin_out) else $error("idle low");
  low_span_a: assert property (serial_clock_pin_oe && $fell(serial_clock_pin_out) |=> !serial_clock_pin_out)
    else $error("short low");
  bit_count_a: assert property (serial_clock_pin_oe && $fell(tx_busy) |-> nf == 4'h8) else $error("count");
  data_edge_a: assert property (serial_clock_pin_oe && tx_busy && $changed(serial_data_out_pin)
    |-> !serial_clock_pin_out) else $error("data moved");
  mode_zero_a: assert property (reg_read && reg_addr == 16'hFF66 |=> reg_rdata[6:2] == 5'h00)
    else $error("mode bits");
  cover property ($fell(tx_busy) && serial_clock_pin_oe);
  cover property ($fell(tx_busy) && !serial_clock_pin_oe);
  cover property (tx_done_irq_flag && tx_done_irq_clear);
endmodule
bind stx_shifter stx_chk u_chk (.*);
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the transmit-only serial shifter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, tx_done_irq_clear = 0, clock_pin_direction = 0;
  logic data_pin_direction = 0, clock_port_pin = 0, data_port_pin = 0, ext_go = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, got, d;
  wire tx_done_irq_flag, serial_clock_pin_out, serial_clock_pin_oe, serial_data_out_pin, serial_data_out_oe;
  wire tx_busy, serial_clock_pin_in;
  int failures = 0, num_checks = 0, n;
  stx_shifter dut (.*);
  stx_rx_model m (.*);
  initial forever #5 clock = ~clock;
  function automatic int per(input int s); return 2 << s; endfunction
  task automatic chk(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin failures++; $display("[FAIL] %0t seen %h want %h", $time, seen, exp); end
  endtask
  task automatic acc(input logic [15:0] a, input logic [7:0] v, input logic w);
    @(negedge clock); reg_addr = a; reg_wdata = v; reg_write = w; reg_read = !w;
    @(negedge clock); reg_write = 0; reg_read = 0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin #300000; failures++; conclude; end
  initial begin
    void'($urandom(32'hE2F2));
    repeat (16) @(negedge clock);
    reset = 0;
    acc(16'hFF66, 8'h00, 0); chk(reg_rdata, 8'h00);
    acc(16'hFF70, 8'h00, 0); chk(reg_rdata, 8'h00);
    d = 8'($urandom); acc(16'hFF67, d, 1); acc(16'hFF67, 8'h00, 0); chk(reg_rdata, d);
    chk(8'(tx_busy), 8'h00); chk(8'(serial_data_out_oe), 8'h01); chk(8'(serial_data_out_pin), 8'h00);
    acc(16'hFF66, 8'h81, 1); repeat (20) @(negedge clock); chk(8'(tx_busy), 8'h00);
    for (int s = 3; s >= 0; s--) begin
      clock_pin_direction = (s == 0);
      acc(16'hFF66, {6'h20, 2'(s)}, 1); acc(16'hFF66, 8'h00, 0); chk(reg_rdata, {6'h20, 2'(s)});
      d = (s == 3) ? 8'h81 : 8'($urandom); acc(16'hFF67, d, 1); ext_go = (s == 0);
      acc(16'hFF67, ~d, 1); // a write while busy must be ignored
      n = 3;
      while (tx_busy === 1'b1 && n < 1000) begin @(negedge clock); n++; end
      chk(got, d); chk(8'(tx_done_irq_flag), 8'h01);
      if (s > 0) chk(8'(n >= 8 * per(s) - 2 && n <= 8 * per(s) + 4), 8'h01);
      ext_go = 0; repeat (3) @(negedge clock); chk(8'(tx_done_irq_flag), 8'h01);
      tx_done_irq_clear = 1; @(negedge clock); tx_done_irq_clear = 0; @(negedge clock);
      chk(8'(tx_done_irq_flag), 8'h00);
    end
    acc(16'hFF66, 8'h00, 1); data_port_pin = 1; repeat (2) @(negedge clock);
    chk(8'(serial_clock_pin_oe), 8'h00); chk(8'(serial_data_out_oe), 8'h01);
    chk(8'(serial_data_out_pin), 8'h01); chk(8'(tx_busy), 8'h00);
    conclude;
  end
endmodule
`default_nettype wire
